// file: design/srs_defines.svh
// Register indices, field positions, reset values and cycle counts.
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define SRS_IDX_BRK_STAT 16'hFE00
`define SRS_IDX_CAUSE 16'hFE01
`define SRS_IDX_BRK_CTRL 16'hFE03
`define SRS_IDX_CFG 16'hFE04
`define SRS_ADDR_W 18

// Reset-cause field positions.
`define SRS_C_POR 7
`define SRS_C_PIN 6
`define SRS_C_WDOG 5
`define SRS_C_OPC 4
`define SRS_C_FETCH 3
`define SRS_C_BO 1

// Break field positions.
`define SRS_B_CLR_EN 7
`define SRS_B_WAIT 1

// Configuration field positions and reset value.
`define SRS_F_WD_DIS 0
`define SRS_F_STOP_OK 1
`define SRS_F_SHORT 2
`define SRS_F_BO_PWD 3
`define SRS_F_BO_RSTD 4
`define SRS_CFG_RST 8'h00

// Reset vectors.
`define SRS_VEC_USER 16'hFFFE
`define SRS_VEC_MON 16'hFEFE

// Counts in oscillator reference cycles.
`define SRS_STAB_CYC 4096
`define SRS_SHORT_CYC 32
`define SRS_DRIVE_CYC 32
`define SRS_HOLD_CYC 32
`define SRS_PIN_CYC 67
`define SRS_PIN_POR_CYC 4163
`define SRS_BUS_DIV 4

`endif

// file: design/srs_pkg.sv
// Types shared by the reset sequencer modules.
`default_nettype none
package srs_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT, ST_STOP, ST_STOP_REC, ST_STAB, ST_DRIVE, ST_HOLD,
    ST_EXT
  } srs_state_t;
endpackage
`default_nettype wire

// file: design/srs_cnt_if.sv
// Link between the sequencer and its stabilisation counter.
`default_nettype none
interface srs_cnt_if;
  logic tick;
  logic clr;
  logic [11:0] cnt;
  modport ctl (output tick, output clr, input cnt);
  modport cnt_side (input tick, input clr, output cnt);
endinterface
`default_nettype wire

// file: design/srs_stab_cnt.sv
// Twelve-bit stabilisation counter advanced by reference clock ticks.
`default_nettype none
module srs_stab_cnt (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control from the sequencer.
  srs_cnt_if.cnt_side c
);
  logic [11:0] cnt_q;

  // Clear wins over a tick; otherwise count each reference tick.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_q <= 12'h000;
    else if (c.clr)
      cnt_q <= 12'h000;
    else if (c.tick)
      cnt_q <= cnt_q + 12'h001;
  end

  assign c.cnt = cnt_q;
endmodule
`default_nettype wire

// file: design/srs_top.sv
// Reset, stop recovery and bus clock sequencer with APB registers.
//
// Operation
// - Bus clock is the selected oscillator or PLL clock divided by four.
// - After power-on or brown-out, bus clocks stay off for 4096 cycles.
// - Stop exit counts reference cycles before clocks restart.
// - Wait mode stops CPU clock; peripheral clock keeps running.
// - Every reset asserts internal reset; vector FFFE, or FEFE in monitor.
// - Internal reset returns break registers to defaults; cause and configuration are kept.
// - Internal resets clear the counter; pin reset leaves it alone.
// - Each reset source sets its own cause flag.
// - Low pin halts; pin flag after 67, or 4163 after power-on.
// - Internal reset drives pin low 32 cycles, then holds 32 more.
// - Power-on and brown-out drive pin low 4096 cycles first.
// - Watchdog request is taken asynchronously to the bus clock.
// - Power-on releases CPU sixty-four cycles after the 4096 count.
// - Power-on sets its flag and clears all other cause flags.
// - Power-on enables source clock while CPU clocks stay off.
// - Watchdog overflow resets and flags unless watchdog is disabled.
// - Illegal instruction sets the bad-opcode flag and resets.
// - Stop with stop disallowed is an illegal-opcode reset.
// - Bad fetch address reset only for an opcode fetch.
// - Cause bits 7..3 power,pin,watchdog,opcode,fetch; bit1 brown-out.
// - Break control bit 7 clear-enable; break status bit 1 wait flag.
// - Data accesses to unmapped addresses never reset.
// - Brown-out resets only when both brown-out disables are zero.
// - Short-wake one gives 32 cycle stop recovery, else 4096.
//
// Local design decision: the APB interface to the registers.
`include "srs_defines.svh"
`default_nettype none
module srs_top #(
  parameter int STAB_CYC = `SRS_STAB_CYC,
  parameter int SHORT_CYC = `SRS_SHORT_CYC,
  parameter int DRIVE_CYC = `SRS_DRIVE_CYC,
  parameter int HOLD_CYC = `SRS_HOLD_CYC,
  parameter int PIN_CYC = `SRS_PIN_CYC,
  parameter int PIN_POR_CYC = `SRS_PIN_POR_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`SRS_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Clock sources and source select, asynchronous.
  input wire logic OSC_REF_CLOCK,
  input wire logic PLL_OUT_CLOCK,
  input wire logic CLK_SRC_SEL,
  // Reset sources, asynchronous.
  input wire logic POWER_ON_PULSE,
  input wire logic BROWNOUT_DET,
  input wire logic WDOG_OVF,
  // Reset pin, open drain.
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OEN,
  // CPU status, same clock.
  input wire logic CPU_FETCH,
  input wire logic CPU_ILLEGAL_OP,
  input wire logic CPU_STOP_EXEC,
  input wire logic CPU_WAIT_EXEC,
  input wire logic ADDR_UNMAPPED,
  input wire logic WAKE_EVENT,
  input wire logic MONITOR_MODE,
  input wire logic BREAK_WAIT,
  // Clock and reset outputs.
  output logic SRC_CLK_EN,
  output logic CPU_CLK,
  output logic PERIPH_CLK,
  output logic INTERNAL_RESET,
  output logic [15:0] RESET_VECTOR,
  output logic BREAK_CLEAR_ENABLE
);
  srs_cnt_if cif ();
  srs_pkg::srs_state_t st_q, st_d;
  logic [6:0] sync1_q, sync2_q;
  logic osc_d_q, src_d_q;
  logic [1:0] div_q;
  logic [7:0] cause_q, cfg_q, brk_ctl_q, brk_st_q;
  logic [12:0] pin_cnt_q;
  logic por_seen_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, oen_q, internal_reset_q, cpu_clk_q, per_clk_q;
  logic [15:0] vec_q;
  logic osc_s, pll_s, sel_s, por_s, bo_s, wd_s, pin_s, src_s;
  logic por_ev, bo_ev, wd_ev, opc_ev, fetch_ev, long_ev, int_ev;
  logic run, ext_ok, done, acc, wr;
  logic [15:0] idx;

  // True on the tick that completes an n-cycle count.
  function automatic logic hit(input logic [11:0] c, input int n);
    return c == 12'(n - 1);
  endfunction

  // Two-flop synchronisers for every asynchronous input.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sync1_q <= 7'h01;
      sync2_q <= 7'h01;
    end
    else
    begin
      sync1_q <= {OSC_REF_CLOCK, PLL_OUT_CLOCK, CLK_SRC_SEL, POWER_ON_PULSE,
                  BROWNOUT_DET, WDOG_OVF, RST_PIN_I};
      sync2_q <= sync1_q;
    end
  end

  assign {osc_s, pll_s, sel_s, por_s, bo_s, wd_s, pin_s} = sync2_q;
  assign src_s = sel_s ? pll_s : osc_s;

  // Reset events; bus-side events only count while the CPU runs.
  assign run = st_q == srs_pkg::ST_RUN;
  assign por_ev = por_s;
  assign bo_ev = bo_s && !cfg_q[`SRS_F_BO_PWD]
                 && !cfg_q[`SRS_F_BO_RSTD];
  assign wd_ev = wd_s && !cfg_q[`SRS_F_WD_DIS];
  assign opc_ev = run && (CPU_ILLEGAL_OP
                  || (CPU_STOP_EXEC && !cfg_q[`SRS_F_STOP_OK]));
  assign fetch_ev = run && CPU_FETCH && ADDR_UNMAPPED;
  assign long_ev = por_ev || bo_ev;
  assign int_ev = long_ev || wd_ev || opc_ev || fetch_ev;
  assign ext_ok = st_q inside {srs_pkg::ST_RUN, srs_pkg::ST_WAIT,
                               srs_pkg::ST_STOP, srs_pkg::ST_STOP_REC};

  // Reference tick from the synchronised oscillator clock.
  assign cif.tick = osc_s && !osc_d_q;

  // Edge history for the reference and selected source clocks.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      osc_d_q <= 1'b0;
      src_d_q <= 1'b0;
    end
    else
    begin
      osc_d_q <= osc_s;
      src_d_q <= src_s;
    end
  end

  // Next state of the sequencer; internal resets take priority.
  always_comb
  begin
    st_d = st_q;
    done = 1'b0;
    if (int_ev)
      st_d = long_ev ? srs_pkg::ST_STAB : srs_pkg::ST_DRIVE;
    else if (ext_ok && !pin_s)
      st_d = srs_pkg::ST_EXT;
    else
    begin
      unique case (st_q)
        srs_pkg::ST_RUN:
          if (CPU_WAIT_EXEC)
            st_d = srs_pkg::ST_WAIT;
          else if (CPU_STOP_EXEC)
            st_d = srs_pkg::ST_STOP;
        srs_pkg::ST_WAIT:
          if (WAKE_EVENT)
            st_d = srs_pkg::ST_RUN;
        srs_pkg::ST_STOP:
          if (WAKE_EVENT)
            st_d = srs_pkg::ST_STOP_REC;
        srs_pkg::ST_STOP_REC:
        begin
          done = cif.tick && hit(cif.cnt, cfg_q[`SRS_F_SHORT] ? SHORT_CYC
                                                      : STAB_CYC);
          if (done)
            st_d = srs_pkg::ST_RUN;
        end
        srs_pkg::ST_STAB:
        begin
          done = cif.tick && hit(cif.cnt, STAB_CYC);
          if (done)
            st_d = srs_pkg::ST_DRIVE;
        end
        srs_pkg::ST_DRIVE:
        begin
          done = cif.tick && hit(cif.cnt, DRIVE_CYC);
          if (done)
            st_d = srs_pkg::ST_HOLD;
        end
        srs_pkg::ST_HOLD:
        begin
          done = cif.tick && hit(cif.cnt, HOLD_CYC);
          if (done)
            st_d = srs_pkg::ST_RUN;
        end
        srs_pkg::ST_EXT:
          if (pin_s)
            st_d = srs_pkg::ST_RUN;
      endcase
    end
  end

  // Clear on internal resets and timed phases; pin reset leaves it.
  assign cif.clr = int_ev || (st_d != st_q && st_d != srs_pkg::ST_EXT
                   && st_d != srs_pkg::ST_RUN
                   && st_d != srs_pkg::ST_WAIT);

  srs_stab_cnt u_cnt (
    .clk(CLK),
    .rstn(RSTN),
    .c(cif.cnt_side)
  );

  // Sequencer state register.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      st_q <= srs_pkg::ST_STAB;
    else
      st_q <= st_d;
  end

  // Divide the selected source by four and gate the bus clocks.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      div_q <= 2'b00;
      cpu_clk_q <= 1'b0;
      per_clk_q <= 1'b0;
    end
    else
    begin
      if (src_s && !src_d_q)
        div_q <= div_q + 2'b01;
      cpu_clk_q <= run && div_q[1];
      per_clk_q <= (run || st_q == srs_pkg::ST_WAIT) && div_q[1];
    end
  end

  // Pin drive, internal reset and reset vector.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      oen_q <= 1'b0;
      internal_reset_q <= 1'b1;
      vec_q <= `SRS_VEC_USER;
    end
    else
    begin
      oen_q <= !(st_q inside {srs_pkg::ST_STAB,
                              srs_pkg::ST_DRIVE});
      internal_reset_q <= st_q inside {srs_pkg::ST_STAB, srs_pkg::ST_DRIVE,
                             srs_pkg::ST_HOLD, srs_pkg::ST_EXT};
      vec_q <= MONITOR_MODE ? `SRS_VEC_MON : `SRS_VEC_USER;
    end
  end

  // Count reference ticks while the pin is low.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      pin_cnt_q <= 13'h0000;
    else if (pin_s)
      pin_cnt_q <= 13'h0000;
    else if (cif.tick && pin_cnt_q != 13'h1FFF)
      pin_cnt_q <= pin_cnt_q + 13'h0001;
  end

  // Remember a power-on or brown-out until the CPU runs again.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      por_seen_q <= 1'b1;
    else if (long_ev)
      por_seen_q <= 1'b1;
    else if (run)
      por_seen_q <= 1'b0;
  end

  // Reset-cause flags; power-on clears all others.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      cause_q <= 8'h80;
    else if (por_ev)
      cause_q <= 8'h80;
    else
    begin
      if (bo_ev)
        cause_q[`SRS_C_BO] <= 1'b1;
      if (wd_ev)
        cause_q[`SRS_C_WDOG] <= 1'b1;
      if (opc_ev)
        cause_q[`SRS_C_OPC] <= 1'b1;
      if (fetch_ev)
        cause_q[`SRS_C_FETCH] <= 1'b1;
      if (!pin_s && cif.tick && pin_cnt_q == 13'(
          (por_seen_q ? PIN_POR_CYC : PIN_CYC) - 1))
        cause_q[`SRS_C_PIN] <= 1'b1;
    end
  end

  // APB decode; the answer comes one cycle into the access phase.
  assign idx = PADDR[`SRS_ADDR_W-1:2];
  assign acc = PSEL && PENABLE && pready_q;
  assign wr = acc && PWRITE;

  // Configuration register, kept across internal resets.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      cfg_q <= `SRS_CFG_RST;
    else if (wr && idx == `SRS_IDX_CFG)
      cfg_q <= {3'b000, PWDATA[4:0]};
  end

  // Break registers return to defaults on internal reset.
  always_ff @(posedge CLK)
  begin
    if (!RSTN || internal_reset_q)
    begin
      brk_ctl_q <= 8'h00;
      brk_st_q <= 8'h00;
    end
    else
    begin
      if (wr && idx == `SRS_IDX_BRK_CTRL)
        brk_ctl_q[`SRS_B_CLR_EN] <= PWDATA[`SRS_B_CLR_EN];
      if (BREAK_WAIT)
        brk_st_q[`SRS_B_WAIT] <= 1'b1;
      else if (wr && idx == `SRS_IDX_BRK_STAT && !PWDATA[`SRS_B_WAIT])
        brk_st_q[`SRS_B_WAIT] <= 1'b0;
    end
  end

  // Bus answer, read data and error for unmapped indices.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= PSEL && PENABLE && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      if (PSEL && PENABLE && !pready_q)
      begin
        unique case (idx)
          `SRS_IDX_BRK_STAT: prdata_q <= {24'h000000, brk_st_q};
          `SRS_IDX_CAUSE: prdata_q <= {24'h000000, cause_q};
          `SRS_IDX_BRK_CTRL: prdata_q <= {24'h000000, brk_ctl_q};
          `SRS_IDX_CFG: prdata_q <= {24'h000000, cfg_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Output drive; the pin data is a constant low from a flop.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      RST_PIN_O <= 1'b0;
    else
      RST_PIN_O <= 1'b0;
  end

  // Source clock enable comes up once reset has been taken.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      SRC_CLK_EN <= 1'b0;
    else
      SRC_CLK_EN <= 1'b1;
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign RST_PIN_OEN = oen_q;
  assign INTERNAL_RESET = internal_reset_q;
  assign RESET_VECTOR = vec_q;
  assign CPU_CLK = cpu_clk_q;
  assign PERIPH_CLK = per_clk_q;
  assign BREAK_CLEAR_ENABLE = brk_ctl_q[`SRS_B_CLR_EN];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence drive_end_s;
    st_q == srs_pkg::ST_DRIVE ##1 st_q == srs_pkg::ST_HOLD;
  endsequence

  sequence wd_hit_s;
    wd_ev && !por_ev;
  endsequence

  pin_drive_a: assert property (drive_end_s |-> ##1 RST_PIN_OEN
    && INTERNAL_RESET) else $error("pin not released into hold");
  stab_clk_a: assert property (st_q == srs_pkg::ST_STAB |=>
    !CPU_CLK && !PERIPH_CLK) else $error("clock ran in stabilisation");
  wait_clk_a: assert property (st_q == srs_pkg::ST_WAIT |=>
    !CPU_CLK) else $error("cpu clock ran in wait");
  por_cause_a: assert property (por_ev |=> cause_q == 8'h80)
    else $error("power-on cause wrong");
  wdog_rst_a: assert property (wd_hit_s |=> cause_q[`SRS_C_WDOG]
    ##1 INTERNAL_RESET) else $error("watchdog reset missed");
  stop_opc_a: assert property (run && CPU_STOP_EXEC
    && !cfg_q[`SRS_F_STOP_OK] && !por_ev |=> cause_q[`SRS_C_OPC]
    && st_q == srs_pkg::ST_DRIVE) else $error("stop not illegal");
  data_ok_a: assert property (run && !int_ev && pin_s
    && ADDR_UNMAPPED && !CPU_FETCH |=> st_q != srs_pkg::ST_DRIVE)
    else $error("data access reset");
  bo_gate_a: assert property (bo_s && !por_ev
    && (cfg_q[`SRS_F_BO_PWD] || cfg_q[`SRS_F_BO_RSTD])
    |=> $stable(cause_q[`SRS_C_BO])) else $error("brown-out not gated");
  ext_halt_a: assert property (st_q == srs_pkg::ST_EXT |=>
    INTERNAL_RESET && !CPU_CLK) else $error("pin reset did not halt");
  mon_vec_a: assert property (MONITOR_MODE |=>
    RESET_VECTOR == `SRS_VEC_MON) else $error("monitor vector wrong");
endmodule
`default_nettype wire

// file: dv/srs_far_model.sv
// Far side model: clock sources, CPU and detector events, reset wire.
`default_nettype none
module srs_far_model (
  // Bus clock.
  input wire logic clk,
  // Open drain reset pin of the block.
  input wire logic pin_o,
  input wire logic pin_oen,
  // Clocks, wire level and events.
  output logic osc,
  output logic pll,
  output logic pin_i,
  output logic [10:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_low;
  // Reference at 5 MHz, PLL at 6.25 MHz, both off the bus phase.
  initial
  begin
    osc = 1'b0;
    pll = 1'b0;
    ev = '0;
    ext_low = 1'b0;
    #37;
    fork
      forever #100 osc = ~osc;
      forever #80 pll = ~pll;
    join
  end
  // The wire has a pull-up; either party may pull it low.
  assign pin_i = ext_low ? 1'b0 : (pin_oen === 1'b0 ? pin_o : 1'b1);
  // Raises the masked events for n cycles, then lets one edge pass.
  task automatic hold(input logic [10:0] m, input int n);
    ev <= ev | m;
    repeat (n) @(posedge clk);
    ev <= ev & ~m;
    @(posedge clk);
  endtask
  // Pulls the reset wire low for n cycles from outside.
  task automatic pull(input int n);
    ext_low <= 1'b1;
    repeat (n) @(posedge clk);
    ext_low <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench of the reset and clock sequencer.
`include "srs_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] A_BS = 18'(4 * `SRS_IDX_BRK_STAT);
  localparam logic [17:0] A_CA = 18'(4 * `SRS_IDX_CAUSE);
  localparam logic [17:0] A_BC = 18'(4 * `SRS_IDX_BRK_CTRL);
  localparam logic [17:0] A_CF = 18'(4 * `SRS_IDX_CFG);
  localparam logic [17:0] A_UN = 18'h3F808;
  localparam int STAB = 64;
  localparam int R = 10;
  localparam logic [10:0] FE = 11'h001, ILL = 11'h002, STP = 11'h004;
  localparam logic [10:0] WT = 11'h008, UN = 11'h010, WK = 11'h020;
  localparam logic [10:0] MON = 11'h040, BW = 11'h080, POR = 11'h100;
  localparam logic [10:0] BO = 11'h200, WD = 11'h400;
  logic clk, rstn, psel, penable, pwrite, sel, pready, pslverr, er;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic osc, pll, pin_i, pin_o, pin_oen, src_en, cpu_clk, per_clk, ir, bce;
  logic [15:0] vec;
  logic [10:0] ev;
  int mismatches, checks_done, c0, c1, k;
  srs_top #(.STAB_CYC(STAB), .PIN_POR_CYC(131)) DUT (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OSC_REF_CLOCK(osc),
    .PLL_OUT_CLOCK(pll), .CLK_SRC_SEL(sel), .POWER_ON_PULSE(ev[8]),
    .BROWNOUT_DET(ev[9]), .WDOG_OVF(ev[10]), .RST_PIN_I(pin_i),
    .RST_PIN_O(pin_o), .RST_PIN_OEN(pin_oen), .CPU_FETCH(ev[0]),
    .CPU_ILLEGAL_OP(ev[1]), .CPU_STOP_EXEC(ev[2]), .CPU_WAIT_EXEC(ev[3]),
    .ADDR_UNMAPPED(ev[4]), .WAKE_EVENT(ev[5]), .MONITOR_MODE(ev[6]),
    .BREAK_WAIT(ev[7]), .SRC_CLK_EN(src_en), .CPU_CLK(cpu_clk),
    .PERIPH_CLK(per_clk), .INTERNAL_RESET(ir), .RESET_VECTOR(vec),
    .BREAK_CLEAR_ENABLE(bce)
  );
  srs_far_model far (
    .clk(clk), .pin_o(pin_o), .pin_oen(pin_oen), .osc(osc), .pll(pll),
    .pin_i(pin_i), .ev(ev)
  );
  // Bus clock of 50 MHz.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compares a design value with its expectation.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  // Compares a measured count with an allowed span.
  task automatic chkin(input int g, input int l, input int h);
    checks_done++;
    if (g < l || g > h)
    begin
      mismatches++;
      $display("wrong value at %0t: count %0d not in %0d..%0d", $time, g, l, h);
    end
  endtask
  // One APB transfer; read data and error are kept in rd and er.
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look half a cycle early so the answer is seen settled, not racing.
    do @(negedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads the cause register and compares it.
  task automatic cause(input logic [7:0] e);
    apb(1'b0, A_CA, '0);
    chk(rd, {24'h000000, e});
  endtask
  // Measures pin drive and the further hold of an internal reset.
  task automatic seq(input int elo);
    int lo, hi;
    lo = 0;
    hi = 0;
    for (int n = 0; n < 9000; n++)
    begin
      @(posedge clk);
      if (pin_oen === 1'b0) lo++;
      else if (ir === 1'b1) hi++;
      else if (lo > 0) break;
    end
    chkin(lo, elo * R - 20, elo * R + 20);
    chkin(hi, 32 * R - 20, 32 * R + 20);
    chk(pin_o, 1'b0);
  endtask
  // Counts rising edges of the CPU and peripheral clocks over n cycles.
  task automatic edges(input int n);
    logic p0, p1;
    c0 = 0;
    c1 = 0;
    for (int n2 = 0; n2 < n; n2++)
    begin
      p0 = cpu_clk;
      p1 = per_clk;
      @(posedge clk);
      c0 += int'(cpu_clk === 1'b1 && p0 === 1'b0);
      c1 += int'(per_clk === 1'b1 && p1 === 1'b0);
    end
  endtask
  // Power-on stabilisation straight after release of reset.
  task automatic t_por;
    repeat (2) @(posedge clk);
    chk(src_en, 1'b1);
    chk(cpu_clk, 1'b0);
    chk(ir, 1'b1);
    cause(8'h80);
    seq(STAB + 32);
  endtask
  // Register map, read-only cause, unmapped place and break flags.
  task automatic t_regs;
    apb(1'b1, A_BC, 32'hFFFFFFFF);
    apb(1'b0, A_BC, '0);
    chk(rd, 32'h00000080);
    chk(bce, 1'b1);
    apb(1'b1, A_CA, 32'h000000FF);
    cause(8'h80);
    apb(1'b0, A_UN, '0);
    chk(rd, 32'h00000000);
    chk(er, 1'b1);
    far.hold(BW, 1);
    apb(1'b0, A_BS, '0);
    chk(rd, 32'h00000002);
    apb(1'b1, A_BS, '0);
    apb(1'b0, A_BS, '0);
    chk(rd, 32'h00000000);
  endtask
  // Bus clock from each source, then wait mode.
  task automatic t_clk;
    edges(320);
    chkin(c0, 7, 9);
    sel <= 1'b1;
    repeat (40) @(posedge clk);
    edges(320);
    chkin(c0, 9, 11);
    sel <= 1'b0;
    repeat (40) @(posedge clk);
    far.hold(WT, 1);
    repeat (20) @(posedge clk);
    edges(200);
    chkin(c0, 0, 0);
    chkin(c1, 4, 6);
    far.hold(WK, 1);
    repeat (20) @(posedge clk);
    edges(200);
    chkin(c0, 4, 6);
  endtask
  // Internal sources; watchdog and brown-out also with their disables, fetch with its false trigger.
  task automatic t_int;
    far.hold(ILL, 1);
    seq(32);
    cause(8'h90);
    chk(bce, 1'b0);
    chk(vec, 16'hFFFE);
    apb(1'b1, A_CF, 32'h00000001);
    far.hold(WD, 3);
    repeat (60) @(posedge clk);
    chk(ir, 1'b0);
    apb(1'b1, A_CF, '0);
    far.hold(WD, 3);
    seq(32);
    cause(8'hB0);
    far.hold(UN, 2);
    repeat (60) @(posedge clk);
    chk(ir, 1'b0);
    far.hold(FE | UN, 1);
    seq(32);
    cause(8'hB8);
    apb(1'b1, A_CF, 32'h00000010);
    far.hold(BO, 4);
    apb(1'b1, A_CF, 32'h00000008);
    far.hold(BO, 4);
    repeat (60) @(posedge clk);
    chk(ir, 1'b0);
    apb(1'b1, A_CF, '0);
    far.hold(BO, 4);
    seq(STAB + 32);
    cause(8'hBA);
  endtask
  // Pin pulls too short and long enough, then monitor mode vector.
  task automatic t_pin;
    fork
      far.pull(50 * R);
      begin
        repeat (100) @(posedge clk);
        chk(ir, 1'b1);
      end
    join
    for (k = 0; k < 200 && ir !== 1'b0; k++) @(posedge clk);
    cause(8'hBA);
    far.pull(80 * R);
    for (k = 0; k < 200 && ir !== 1'b0; k++) @(posedge clk);
    cause(8'hFA);
    fork
      far.hold(MON, 6);
      begin
        repeat (4) @(posedge clk);
        chk(vec, 16'hFEFE);
      end
    join
    repeat (3) @(posedge clk);
    chk(vec, 16'hFFFE);
  endtask
  // Second power-on, stop refused, then stop with short wake.
  task automatic t_stop;
    far.hold(POR, 4);
    seq(STAB + 32);
    cause(8'h80);
    apb(1'b1, A_CF, '0);
    far.hold(STP, 1);
    seq(32);
    cause(8'h90);
    apb(1'b1, A_CF, 32'h00000006);
    far.hold(STP, 1);
    repeat (20) @(posedge clk);
    edges(100);
    chkin(c0, 0, 0);
    far.hold(WK, 1);
    for (k = 0; k < 1000 && cpu_clk !== 1'b1; k++) @(posedge clk);
    chkin(k, 32 * R - 30, 32 * R + 60);
  endtask
  // Prints the verdict and ends the run.
  task automatic conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence after three cycles of reset.
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sel = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_por();
    t_regs();
    t_clk();
    t_int();
    t_pin();
    t_stop();
    conclude();
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
